// [shared/dac_update_pkg.sv]
// package: constants and carriers for the dac channel update control
package dac_update_pkg;
   localparam int          CHANNELS      = 16;
   localparam int          CODE_W        = 16;
   localparam int          CHAN_W        = 4;
   localparam int          RANGE_W       = 3;
   localparam int          CAL_TIME_NS   = 800;
   localparam int          CLK_PERIOD_NS = 8;
   localparam int          CAL_CYCLES    = (CAL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int          CAL_CNT_W     = 8;
   localparam logic [CODE_W-1:0]  CODE_RESET  = 16'h0000;
   localparam logic [RANGE_W-1:0] RANGE_0_5V  = 3'h0;
   localparam logic [RANGE_W-1:0] RANGE_0_10V = 3'h1;
   localparam logic [RANGE_W-1:0] RANGE_PM5V  = 3'h2;
   localparam logic [RANGE_W-1:0] RANGE_PM10V = 3'h3;
   localparam logic [RANGE_W-1:0] RANGE_4_20MA = 3'h4;
   localparam logic [RANGE_W-1:0] RANGE_0_20MA = 3'h5;
   localparam logic [RANGE_W-1:0] RANGE_0_24MA = 3'h6;

   typedef struct packed {
      logic              valid;
      logic [CHAN_W-1:0] channel;
      logic [CODE_W-1:0] output_code_value;
   } code_write_t;

   typedef struct packed {
      logic               valid;
      logic [CHAN_W-1:0]  channel;
      logic [RANGE_W-1:0] range;
      logic               over_range;
      logic               clear_on_chip_clear_enable;
      logic               calibration_load_select;
   } settings_write_t;

   typedef enum logic [2:0] {
      CAL_IDLE = 3'b001,
      CAL_BUSY = 3'b010,
      CAL_DONE = 3'b100
   } cal_state_t;
endpackage : dac_update_pkg

// [testbench/tb_dac_channel_update_control.sv]
// self-checking bench for the dac channel update control, with an integer model
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin n_errors++; $display("Error %s expected %h seen %h", nm, ex, got); end end
module tb_dac_channel_update_control
   import dac_update_pkg::*;
;
   logic                     clk = 1'b0;
   logic                     reset_n = 1'b0;
   logic                     sel = 1'b0;
   logic                     upd = 1'b0;
   logic                     clr = 1'b0;
   code_write_t              cw = '0;
   settings_write_t          sw = '0;
   logic [CHANNELS*CODE_W-1:0]  output_codes;
   logic [CHANNELS*RANGE_W-1:0] output_ranges;
   logic [CHANNELS-1:0]      over_range_active;
   logic [CHANNELS-1:0]      current_mode;
   logic [CHANNELS-1:0]      calibration_fetch;
   logic                     calibration_busy;
   logic [31:0]              lf = 32'h69AD;
   logic [15:0]              scan_channel_flags;
   int                       act[16], pend[16], rng[16], ovr[16], cen[16];
   int                       n_errors = 0;
   int                       n_checks = 0;

   dac_channel_update_control #(.NUM_CHANNELS(CHANNELS)) i_dac_channel_update_control (
      .clk(clk), .reset_n(reset_n), .simultaneous_update_select(sel), .code_write(cw),
      .settings_write(sw), .update_command(upd), .chip_clear(clr),
      .output_codes(output_codes), .output_ranges(output_ranges),
      .over_range_active(over_range_active), .current_mode(current_mode),
      .calibration_fetch(calibration_fetch), .calibration_busy(calibration_busy));

   always #4 clk = ~clk;

   function automatic logic [31:0] lfsr(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction : lfsr

   task automatic tick;
      @(posedge clk);
      #1;
   endtask : tick

   task automatic check_all;
      logic [255:0] ec;
      logic [47:0]  er;
      logic [15:0]  eo, em;
      for (int i = 0; i < 16; i++) begin
         ec[16*i+:16] = 16'(act[i]);
         er[3*i+:3]   = 3'(rng[i]);
         eo[i]        = (ovr[i] != 0) && (rng[i] < 4);
         em[i]        = rng[i] >= 4;
      end
      `CHK("codes", ec, output_codes)
      `CHK("ranges", er, output_ranges)
      `CHK("over_range", eo, over_range_active)
      `CHK("current", em, current_mode)
   endtask : check_all

   task automatic set_cfg(input int ch, input int r, input bit o, input bit c, input bit l);
      logic [15:0] f;
      sw = '{1'b1, 4'(ch), 3'(r), o, c, l};
      tick();
      sw.valid = 1'b0;
      rng[ch] = (r == 7) ? 0 : r;
      ovr[ch] = o;
      cen[ch] = c;
      f = '0;
      f[ch] = l;
      `CHK("fetch", f, calibration_fetch)
      check_all();
   endtask : set_cfg

   task automatic write_code(input int ch, input logic [15:0] v);
      int n;
      cw = '{1'b1, 4'(ch), v};
      tick();
      cw.valid = 1'b0;
      pend[ch] = v;
      check_all();
      if (!sel) begin
         `CHK("busy", 1'b1, calibration_busy)
         n = 0;
         while (calibration_busy === 1'b1 && n < 300) begin
            check_all();
            tick();
            n++;
         end
         `CHK("busy_end", 1'b0, calibration_busy)
         `CHK("cal_cycles", CAL_CYCLES + 1, n)
         act[ch] = v;
         check_all();
      end
   endtask : write_code

   task automatic pulse(input bit is_clr);
      if (is_clr) clr = 1'b1; else upd = 1'b1;
      tick();
      clr = 1'b0;
      upd = 1'b0;
      for (int i = 0; i < 16; i++) begin
         if (is_clr && cen[i] != 0) begin
            act[i] = 0;
            pend[i] = 0;
         end else if (!is_clr && sel) act[i] = pend[i];
      end
      check_all();
   endtask : pulse

   task automatic wrap_up;
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : wrap_up

   initial begin
      #20000;
      n_errors++;
      wrap_up();
   end

   initial begin
      foreach (act[i]) begin act[i] = 0; pend[i] = 0; rng[i] = 0; ovr[i] = 0; cen[i] = 0; end
      repeat (3) tick();
      `CHK("reset_fetch", 16'hFFFF, calibration_fetch)
      `CHK("reset_busy", 1'b0, calibration_busy)
      check_all();
      reset_n = 1'b1;
      tick();
      `CHK("fetch_off", 16'h0000, calibration_fetch)
      $display("test reset done");
      for (int r = 0; r < 8; r++) set_cfg(r, r, 1'b1, r[0], r[1]);
      set_cfg(0, 0, 1'b0, 1'b0, 1'b1);
      $display("test settings done");
      write_code(15, 16'hFFFF);
      write_code(0, 16'h0000);
      for (int k = 0; k < 4; k++) begin
         lf = lfsr(lf);
         write_code(int'(lf[19:16]), lf[15:0]);
      end
      $display("test single mode done");
      sel = 1'b1;
      tick();
      write_code(1, 16'h1234);
      write_code(2, 16'hABCD);
      write_code(1, 16'h8001);
      pulse(1'b0);
      for (int k = 0; k < 4; k++) begin
         lf = lfsr(lf);
         write_code(int'(lf[19:16]), lf[15:0]);
      end
      pulse(1'b0);
      write_code(4, 16'h4242);
      sel = 1'b0;
      tick();
      pulse(1'b0);
      sel = 1'b1;
      tick();
      pulse(1'b0);
      $display("test simultaneous mode done");
      write_code(3, 16'h7777);
      write_code(5, 16'h5555);
      pulse(1'b0);
      write_code(3, 16'h3333);
      pulse(1'b1);
      pulse(1'b0);
      $display("test chip clear done");
      lf = lfsr(lf);
      scan_channel_flags = lf[15:0];
      for (int i = 0; i < 16; i++) begin
         if (scan_channel_flags[i]) write_code(i, lf[31:16] ^ 16'(i));
      end
      pulse(1'b0);
      $display("test scan done");
      wrap_up();
   end
endmodule : tb_dac_channel_update_control

// [verilog/dac_channel_update_control.sv]
// dac channel update control: pending/active codes, settings, update modes
// How it works
// - one mode bit: 0 single-channel update, 1 simultaneous update
// - single mode: written code reaches output after calibration delay, unless a write to another channel restarts the delay first
// - simultaneous mode: write stores code, output stays unchanged
// - update command in simultaneous mode applies every pending code at the same moment; ignored in single mode
// - each write carries 16-bit code to one channel 0 to 15
// - over-range 1 widens voltage ranges 20 percent; dropped on current ranges
// - clear enable decides whether channel clears on chip clear
// - calibration load 1 fetches gain/offset for range; 0 keeps it
// - after reset all channels 0-5V with unipolar calibration loaded
`timescale 1ns/100ps
module dac_channel_update_control
   import dac_update_pkg::*;
#(
   parameter int NUM_CHANNELS = CHANNELS
) (
   input  wire logic                          clk,
   input  wire logic                          reset_n,
   input  wire logic                          simultaneous_update_select,
   input  wire code_write_t                   code_write,
   input  wire settings_write_t               settings_write,
   input  wire logic                          update_command,
   input  wire logic                          chip_clear,
   output logic [NUM_CHANNELS*CODE_W-1:0]     output_codes,
   output logic [NUM_CHANNELS*RANGE_W-1:0]    output_ranges,
   output logic [NUM_CHANNELS-1:0]            over_range_active,
   output logic [NUM_CHANNELS-1:0]            current_mode,
   output logic [NUM_CHANNELS-1:0]            calibration_fetch,
   output logic                               calibration_busy
);
   logic [CODE_W-1:0]  pending   [NUM_CHANNELS];
   logic [CODE_W-1:0]  active    [NUM_CHANNELS];
   logic [RANGE_W-1:0] range_sel [NUM_CHANNELS];
   logic [NUM_CHANNELS-1:0] ovr, clr_en;
   logic [CODE_W-1:0]  next_pending   [NUM_CHANNELS];
   logic [CODE_W-1:0]  next_active    [NUM_CHANNELS];
   logic [RANGE_W-1:0] next_range_sel [NUM_CHANNELS];
   logic [NUM_CHANNELS-1:0] next_ovr, next_clr_en, next_cal_req;
   cal_state_t         state, next_state;
   logic [CAL_CNT_W-1:0] cal_cnt, next_cal_cnt;
   logic [CHAN_W-1:0]  cal_chan, next_cal_chan;
   logic [NUM_CHANNELS*CODE_W-1:0]  next_output_codes;
   logic [NUM_CHANNELS*RANGE_W-1:0] next_output_ranges;
   logic [NUM_CHANNELS-1:0]         next_over_range_active;
   logic [NUM_CHANNELS-1:0]         next_current_mode;
   logic                            next_calibration_busy;
   // flat copy of the pending codes, only for the update check
   logic [NUM_CHANNELS*CODE_W-1:0]  pending_flat;

   function automatic logic is_current(input logic [RANGE_W-1:0] r);
      is_current = (r == RANGE_4_20MA) || (r == RANGE_0_20MA) || (r == RANGE_0_24MA);
   endfunction : is_current

   function automatic logic [RANGE_W-1:0] legal_range(input logic [RANGE_W-1:0] r);
      legal_range = (r > RANGE_0_24MA) ? RANGE_0_5V : r;
   endfunction : legal_range

   // write-to-output path; calibration delay only matters in single mode
   always_comb begin
      next_state    = state;
      next_cal_cnt  = cal_cnt;
      next_cal_chan = cal_chan;
      for (int i = 0; i < NUM_CHANNELS; i++) begin
         next_pending[i]   = pending[i];
         next_active[i]    = active[i];
         next_range_sel[i] = range_sel[i];
      end
      next_ovr     = ovr;
      next_clr_en  = clr_en;
      next_cal_req = '0;
      if (settings_write.valid) begin
         next_range_sel[settings_write.channel] = legal_range(settings_write.range);
         // over-range silently dropped on current ranges
         next_ovr[settings_write.channel] = settings_write.over_range
            && !is_current(settings_write.range);
         next_clr_en[settings_write.channel] = settings_write.clear_on_chip_clear_enable;
         next_cal_req[settings_write.channel] = settings_write.calibration_load_select;
      end
      if (code_write.valid) begin
         // later write overwrites pending value
         next_pending[code_write.channel] = code_write.output_code_value;
      end
      case (state)
         CAL_IDLE: begin
            if (code_write.valid && !simultaneous_update_select) begin
               next_state    = CAL_BUSY;
               next_cal_cnt  = CAL_CNT_W'(CAL_CYCLES - 1);
               next_cal_chan = code_write.channel;
            end
         end
         CAL_BUSY: begin
            if (code_write.valid && !simultaneous_update_select) begin
               next_cal_cnt  = CAL_CNT_W'(CAL_CYCLES - 1);
               next_cal_chan = code_write.channel;
            end else if (cal_cnt == '0) begin
               next_state = CAL_DONE;
            end else begin
               next_cal_cnt = cal_cnt - 1'b1;
            end
         end
         CAL_DONE: begin
            next_active[cal_chan] = pending[cal_chan];
            next_state = CAL_IDLE;
         end
         default: next_state = CAL_IDLE;
      endcase
      if (update_command && simultaneous_update_select) begin
         for (int i = 0; i < NUM_CHANNELS; i++) begin
            next_active[i] = pending[i];
         end
      end
      if (chip_clear) begin
         for (int i = 0; i < NUM_CHANNELS; i++) begin
            if (clr_en[i]) begin
               next_active[i]  = CODE_RESET;
               next_pending[i] = CODE_RESET;
            end
         end
      end
   end

   always_comb begin
      for (int i = 0; i < NUM_CHANNELS; i++) begin
         next_output_codes[i*CODE_W +: CODE_W]    = next_active[i];
         pending_flat[i*CODE_W +: CODE_W]         = pending[i];
         next_output_ranges[i*RANGE_W +: RANGE_W] = next_range_sel[i];
         next_current_mode[i] = is_current(next_range_sel[i]);
      end
      next_over_range_active = next_ovr;
      next_calibration_busy  = (next_state != CAL_IDLE);
   end

   // reset gives 0-5V everywhere; unipolar calibration fetch requested for all
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         for (int i = 0; i < NUM_CHANNELS; i++) begin
            pending[i]   <= CODE_RESET;
            active[i]    <= CODE_RESET;
            range_sel[i] <= RANGE_0_5V;
         end
         ovr               <= '0;
         clr_en            <= '0;
         state             <= CAL_IDLE;
         cal_cnt           <= '0;
         cal_chan          <= '0;
         output_codes      <= '0;
         output_ranges     <= '0;
         over_range_active <= '0;
         current_mode      <= '0;
         calibration_fetch <= '1;
         calibration_busy  <= 1'b0;
      end else begin
         for (int i = 0; i < NUM_CHANNELS; i++) begin
            pending[i]   <= next_pending[i];
            active[i]    <= next_active[i];
            range_sel[i] <= next_range_sel[i];
         end
         ovr               <= next_ovr;
         clr_en            <= next_clr_en;
         state             <= next_state;
         cal_cnt           <= next_cal_cnt;
         cal_chan          <= next_cal_chan;
         output_codes      <= next_output_codes;
         output_ranges     <= next_output_ranges;
         over_range_active <= next_over_range_active;
         current_mode      <= next_current_mode;
         calibration_fetch <= next_cal_req;
         calibration_busy  <= next_calibration_busy;
      end
   end

   // a finishing single-mode write may still land, so that cycle is left out
   sequence sim_write_s;
      code_write.valid && simultaneous_update_select && !update_command && !chip_clear
         && state != CAL_DONE;
   endsequence

   sequence update_s;
      update_command && simultaneous_update_select && !chip_clear;
   endsequence

   chk_sim_holds_output: assert property (@(posedge clk) disable iff (!reset_n)
      sim_write_s |=> $stable(output_codes))
      else $error("output changed without update command");

   chk_update_applies: assert property (@(posedge clk) disable iff (!reset_n)
      update_s |=> output_codes == $past(pending_flat))
      else $error("update command did not apply pending code");

   chk_single_timing: assert property (@(posedge clk) disable iff (!reset_n)
      (state == CAL_IDLE && code_write.valid && !simultaneous_update_select)
      |=> calibration_busy ##[1:300] !calibration_busy)
      else $error("single-channel update not completed in time");

   chk_ovr_voltage_only: assert property (@(posedge clk) disable iff (!reset_n)
      (over_range_active & current_mode) == '0)
      else $error("over-range active on current range");

   chk_range_legal: assert property (@(posedge clk) disable iff (!reset_n)
      settings_write.valid |=> output_ranges[$past(settings_write.channel)*RANGE_W +: RANGE_W]
         == (($past(settings_write.range) > RANGE_0_24MA) ? RANGE_0_5V
                                                           : $past(settings_write.range)))
      else $error("illegal range code at output");

   // per channel, since the clear enable differs channel by channel
   for (genvar g = 0; g < NUM_CHANNELS; g++) begin : g_clear_chk
      chk_clear_zeroes: assert property (@(posedge clk) disable iff (!reset_n)
         (chip_clear && clr_en[g]) |=> output_codes[g*CODE_W +: CODE_W] == CODE_RESET)
         else $error("enabled channel not cleared");

      chk_clear_ignored: assert property (@(posedge clk) disable iff (!reset_n)
         (chip_clear && !clr_en[g] && !update_command
          && !(state == CAL_DONE && cal_chan == CHAN_W'(g)))
         |=> $stable(output_codes[g*CODE_W +: CODE_W]))
         else $error("disabled channel was cleared");
   end

   chk_cal_fetch: assert property (@(posedge clk) disable iff (!reset_n)
      settings_write.valid |=> calibration_fetch[$past(settings_write.channel)]
                               == $past(settings_write.calibration_load_select))
      else $error("calibration fetch mismatch");

   chk_latest_wins: assert property (@(posedge clk) disable iff (!reset_n)
      (code_write.valid && !chip_clear) |=> pending[$past(code_write.channel)]
                                            == $past(code_write.output_code_value))
      else $error("pending code not replaced");
endmodule : dac_channel_update_control
